// >>> rtl/usb_host_irq_enable_flag.sv
// host interrupt enable and flag registers behind a classic wishbone slave
//
// Contract
// - write one to clear view drops enable
// - write one to set view raises enable
// - both views read the same enables
// - request while flag and enable set
// - flag cleared only by writing one
// - detach sets flag bit nine
// - attach sets flag bit eight
// - out-stage memory error sets bit seven
// - upstream resume sets bit six
// - finished downstream resume sets bit five
// - wake flag on three conditions
// - finished bus reset sets bit three
// - each frame start sets bit two
// - frame start updates frame number
// - reserved bits read zero
//
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "host_irq_cfg.svh"
module usb_host_irq_enable_flag (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             wb_err_o,
  // host port events, one-cycle pulses
  input  wire logic        peripheral_attached_i,
  input  wire logic        peripheral_detached_i,
  input  wire logic        buffer_memory_error_i,
  input  wire logic        remote_resume_received_i,
  input  wire logic        downstream_resume_sent_i,
  input  wire logic        bus_reset_sent_i,
  input  wire logic        frame_start_sent_i,
  input  wire logic [10:0] frame_number_i,
  // port state levels
  input  wire logic        frame_generation_on_i,
  input  wire logic        bus_power_good_i,
  // interrupt
  output logic             irq_o
);

  // ************************************************
  // state
  // ************************************************
  typedef struct packed {
    host_irq_pkg::bus_state_t bus;       // slave state
    logic [31:0]              rdata;     // read data
    logic                     err;       // error answer
    logic [15:0]              enables;   // shared enable bits
    logic [10:0]              frame_number;      // frame number seen by software
    logic                     irq;       // registered request
  } top_state_t;
  top_state_t state;       // current
  top_state_t next_state;  // next

  host_irq_if flag_port ();  // strobes to the flag store

  logic        access;     // request present
  logic        wr_lo;      // low half written
  logic [15:0] wmask;      // write data in low half under byte enables
  logic [15:0] next_irq_src;

  // ************************************************
  // flag store
  // ************************************************
  sticky_flags u_flags (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .port     (flag_port.store)
  );

  // event vector and clear strobes
  always_comb begin
    flag_port.set_bits = 16'h0000;
    flag_port.set_bits[`BIT_DETACHED]  = peripheral_detached_i;
    flag_port.set_bits[`BIT_ATTACHED]  = peripheral_attached_i;
    flag_port.set_bits[`BIT_MEM_ERROR] = buffer_memory_error_i;
    flag_port.set_bits[`BIT_UP_RESUME] = remote_resume_received_i;
    flag_port.set_bits[`BIT_DN_RESUME] = downstream_resume_sent_i;
    flag_port.set_bits[`BIT_BUS_RESET] = bus_reset_sent_i;
    flag_port.set_bits[`BIT_FRAME_START] = frame_start_sent_i;
    // wake: suspended with resume or detach, or powered with attach
    flag_port.set_bits[`BIT_WAKE] =
      (!frame_generation_on_i && (remote_resume_received_i || peripheral_detached_i)) ||
      (bus_power_good_i && peripheral_attached_i);
    flag_port.clr_bits = 16'h0000;
    if (wr_lo && wb_adr_i == `OFF_FLAGS) begin
      flag_port.clr_bits = wmask & `IMPL_MASK;
    end
  end

  // ************************************************
  // bus decode
  // ************************************************
  assign access = wb_cyc_i && wb_stb_i && state.bus == host_irq_pkg::BUS_IDLE;
  assign wr_lo  = access && wb_we_i;
  assign wmask  = wb_dat_i[15:0] & {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // next state of slave, enables and frame number
  always_comb begin
    next_state = state;
    // enable views
    if (wr_lo && wb_adr_i == `OFF_ENABLE_SET) begin
      next_state.enables = (state.enables | wmask) & `IMPL_MASK;
    end else if (wr_lo && wb_adr_i == `OFF_ENABLE_CLEAR) begin
      next_state.enables = state.enables & ~wmask;
    end
    // frame number follows each frame start
    if (frame_start_sent_i) begin
      next_state.frame_number = frame_number_i;
    end
    // bus answer
    case (state.bus)
      host_irq_pkg::BUS_IDLE: begin
        if (access) begin
          next_state.bus   = host_irq_pkg::BUS_ACK;
          next_state.err   = 1'b0;
          next_state.rdata = 32'h0000_0000;
          if (wb_adr_i == `OFF_ENABLE_SET) begin
            next_state.rdata = {16'h0000, state.enables};
          end else if (wb_adr_i == `OFF_ENABLE_CLEAR) begin
            next_state.rdata = {16'h0000, state.enables};
          end else if (wb_adr_i == `OFF_FLAGS) begin
            next_state.rdata = {16'h0000, flag_port.flags};
          end else if (wb_adr_i == `OFF_FRAME_NUMBER) begin
            next_state.rdata = {18'h0_0000, state.frame_number, 3'h0};
          end else if (wb_adr_i == `OFF_PORT_STATE) begin
            next_state.rdata = {30'h0000_0000, bus_power_good_i, frame_generation_on_i};
          end else begin
            next_state.err = 1'b1;  // unmapped address
          end
        end
      end
      host_irq_pkg::BUS_ACK: begin
        next_state.bus = host_irq_pkg::BUS_IDLE;  // ack lasts one cycle
        next_state.err = 1'b0;
      end
      default: begin
        next_state.bus = host_irq_pkg::BUS_IDLE;
      end
    endcase
    // request from the pairs of flag and enable
    next_irq_src   = flag_port.flags & state.enables;
    next_state.irq = |next_irq_src;
  end

  // register the state
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= '{bus: host_irq_pkg::BUS_IDLE, rdata: 32'h0000_0000, err: 1'b0,
                 enables: `ENABLE_RESET, frame_number: `FRAME_NUMBER_RESET, irq: 1'b0};
    end else begin
      state <= next_state;
    end
  end

  // ************************************************
  // outputs
  // ************************************************
  assign wb_dat_o = state.rdata;
  assign wb_ack_o = state.bus == host_irq_pkg::BUS_ACK && !state.err;
  assign wb_err_o = state.bus == host_irq_pkg::BUS_ACK && state.err;
  assign irq_o    = state.irq;
endmodule // usb_host_irq_enable_flag

// >>> rtl/host_irq_cfg.svh
// register offsets, field positions and reset values of the host interrupt block
`ifndef HOST_IRQ_CFG_SVH
`define HOST_IRQ_CFG_SVH
`define OFF_ENABLE_CLEAR   8'h14
`define OFF_ENABLE_SET     8'h18
`define OFF_FLAGS          8'h1c
`define OFF_FRAME_NUMBER   8'h10
`define OFF_PORT_STATE     8'h24
`define BIT_FRAME_START    2
`define BIT_BUS_RESET      3
`define BIT_WAKE           4
`define BIT_DN_RESUME      5
`define BIT_UP_RESUME      6
`define BIT_MEM_ERROR      7
`define BIT_ATTACHED       8
`define BIT_DETACHED       9
`define IMPL_MASK          16'h03fc
`define ENABLE_RESET       16'h0000
`define FLAGS_RESET        16'h0000
`define FRAME_NUMBER_RESET         11'h000
`define FRAME_NUMBER_LSB           3
`define FRAME_NUMBER_MSB           13
`define BIT_FRAME_GEN_ON   0
`define BIT_BUS_POWER_GOOD 1
`endif

// >>> rtl/host_irq_pkg.sv
// types shared by the host interrupt block
package host_irq_pkg;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } bus_state_t;
  typedef logic [15:0] reg16_t;
endpackage

// >>> rtl/host_irq_if.sv
// set and clear strobes carried from the register block into the flag store
`timescale 1ns/1ps
interface host_irq_if;
  logic [15:0] set_bits;  // event strobes
  logic [15:0] clr_bits;  // software clear strobes
  logic [15:0] flags;     // flag contents
  modport store (input set_bits, input clr_bits, output flags);
  modport ctrl  (output set_bits, output clr_bits, input flags);
endinterface

// >>> rtl/sticky_flags.sv
// sticky event flags: hardware set wins over software clear
`timescale 1ns/1ps
`include "host_irq_cfg.svh"
module sticky_flags (
  // clock and reset
  input  wire logic   clk_i,
  input  wire logic   arst_n_i,
  // strobes
  host_irq_if.store   port
);
  typedef struct packed {
    logic [15:0] flags;  // stored flags
  } flag_state_t;
  flag_state_t state;       // current
  flag_state_t next_state;  // next

  // clear on write one, set on event; set has priority
  always_comb begin
    next_state = state;
    next_state.flags = ((state.flags & ~port.clr_bits) | port.set_bits) & `IMPL_MASK;
  end

  // register the state
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= '{flags: `FLAGS_RESET};
    end else begin
      state <= next_state;
    end
  end

  assign port.flags = state.flags;
endmodule // sticky_flags

// >>> sim/usb_host_irq_enable_flag_props.sv
// concurrent checks on the ports of the host interrupt block
`timescale 1ns/1ps
`include "host_irq_cfg.svh"
module usb_host_irq_enable_flag_props (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        arst_n_i,
  // bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        wb_err_o,
  // events and interrupt
  input wire logic        peripheral_attached_i,
  input wire logic        peripheral_detached_i,
  input wire logic        buffer_memory_error_i,
  input wire logic        remote_resume_received_i,
  input wire logic        downstream_resume_sent_i,
  input wire logic        bus_reset_sent_i,
  input wire logic        frame_start_sent_i,
  input wire logic        irq_o
);
  // a write may change enables or flags
  logic wr_req;
  // any event that may set a flag
  logic evt;
  // address decodes to a register
  logic mapped;
  assign wr_req = wb_cyc_i && wb_stb_i && wb_we_i;
  assign evt = |{peripheral_attached_i, peripheral_detached_i, buffer_memory_error_i,
                 remote_resume_received_i, downstream_resume_sent_i, bus_reset_sent_i,
                 frame_start_sent_i};
  assign mapped = wb_adr_i inside {`OFF_ENABLE_CLEAR, `OFF_ENABLE_SET, `OFF_FLAGS,
                                   `OFF_FRAME_NUMBER, `OFF_PORT_STATE};
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  AST_ONE_ANSWER: assert property (!(wb_ack_o && wb_err_o)) else $error("ack with err");
  AST_ACK_MAPPED: assert property ($rose(wb_stb_i) && wb_cyc_i && mapped |=> wb_ack_o)
    else $error("no ack");
  AST_ERR_UNMAPPED: assert property ($rose(wb_stb_i) && wb_cyc_i && !mapped
    |=> wb_err_o && !wb_ack_o) else $error("no err");
  AST_IDLE_QUIET: assert property (!wb_cyc_i |=> !wb_ack_o && !wb_err_o) else $error("stray");
  AST_RSVD_ZERO: assert property (wb_ack_o && !$past(wb_we_i) && ($past(wb_adr_i) inside
    {`OFF_ENABLE_CLEAR, `OFF_ENABLE_SET, `OFF_FLAGS}) |-> (wb_dat_o & 32'hffff_fc03) == 0)
    else $error("reserved bits set");
  // the request lags an event or a write by one more edge, so look one edge back too
  AST_IRQ_CAUSE: assert property (!irq_o && !evt && !wr_req && !$past(evt) && !$past(wr_req)
    |=> !irq_o) else $error("irq without cause");
  AST_IRQ_HOLD: assert property (irq_o && !wr_req |=> irq_o) else $error("irq dropped");
endmodule // usb_host_irq_enable_flag_props
bind usb_host_irq_enable_flag usb_host_irq_enable_flag_props u_props (.clk_i, .arst_n_i,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .wb_err_o,
  .peripheral_attached_i, .peripheral_detached_i, .buffer_memory_error_i,
  .remote_resume_received_i, .downstream_resume_sent_i, .bus_reset_sent_i,
  .frame_start_sent_i, .irq_o);

// >>> sim/host_port_model.sv
// host port model: turns bench requests into one-cycle event pulses
`timescale 1ns/1ps
module host_port_model (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  // requests, one bit per event
  input  wire logic [6:0]  fire_i,
  // pulses and frame number
  output logic      [6:0]  pulse_o,
  output logic      [10:0] frame_number_o
);
  // pulses follow requests by one cycle; a frame start advances the number
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pulse_o        <= 7'h00;
      frame_number_o <= 11'h000;
    end else begin
      pulse_o <= fire_i;
      if (fire_i[0]) frame_number_o <= frame_number_o + 11'h001;
    end
  end
endmodule // host_port_model

// >>> sim/usb_host_irq_enable_flag_tb.sv
// self-checking bench for the host interrupt enable and flag block
`timescale 1ns/1ps
`include "host_irq_cfg.svh"
module usb_host_irq_enable_flag_tb;
  logic        clk_i, arst_n_i, cyc, stb, we, ack, err, irq, fgo, bpg, rerr;
  logic [7:0]  adr;
  logic [31:0] dat, q, rdat;
  logic [6:0]  fire, pls;
  logic [10:0] frame_number;
  int          mismatches, check_count, frames;
  int          bt[7] = '{2, 3, 5, 6, 7, 8, 9};
  usb_host_irq_enable_flag u_usb_host_irq_enable_flag (.clk_i, .arst_n_i, .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(4'h3),
    .wb_dat_o(q), .wb_ack_o(ack), .wb_err_o(err), .frame_start_sent_i(pls[0]),
    .bus_reset_sent_i(pls[1]), .downstream_resume_sent_i(pls[2]),
    .remote_resume_received_i(pls[3]), .buffer_memory_error_i(pls[4]),
    .peripheral_attached_i(pls[5]), .peripheral_detached_i(pls[6]), .frame_number_i(frame_number),
    .frame_generation_on_i(fgo), .bus_power_good_i(bpg), .irq_o(irq));
  host_port_model u_host_port_model (.clk_i, .arst_n_i, .fire_i(fire), .pulse_o(pls),
    .frame_number_o(frame_number));
  // free-running clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s exp %h seen %h", s, exp, seen);
    end
  endtask
  // one classic cycle, held until ack or err
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc, stb, we, adr, dat} <= {1'b1, 1'b1, w, a, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && err !== 1'b1 && n < 20);
    rdat = q;
    rerr = err;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20) begin
      mismatches++;
      tally_and_finish();
    end
  endtask
  // the request follows a write one edge after the ack edge
  task automatic settle;
    @(posedge clk_i);
  endtask
  // fire one event, let flag and irq land, read flags
  task automatic ev(input int k, input logic [15:0] e);
    @(posedge clk_i) fire <= 7'h01 << k;
    @(posedge clk_i) fire <= 7'h00;
    repeat (3) @(posedge clk_i);
    if (k == 0) frames++;
    wb(0, `OFF_FLAGS, 0);
    chk("flags", rdat, {16'h0000, e});
  endtask
  // main sequence
  initial begin
    {arst_n_i, cyc, stb, we, adr, dat, fire, fgo, bpg} = '0;
    fgo = 1'b1;
    repeat (8) @(posedge clk_i);
    arst_n_i <= 1'b1;
    foreach (bt[i]) if (i < 3) begin
      wb(0, 8'h14 + 8'(i * 4), 0);
      chk("reset", rdat, 0);
    end
    wb(1, 8'h30, 32'hffff_ffff);
    chk("unmapped err", rerr, 1);
    wb(1, `OFF_ENABLE_SET, {16'h0000, `IMPL_MASK});
    wb(0, `OFF_ENABLE_CLEAR, 0);
    chk("enables", rdat, {16'h0000, `IMPL_MASK});
    for (int k = 0; k < 7; k++) begin
      ev(k, 16'h0001 << bt[k]);
      chk("irq on", irq, 1);
      wb(1, `OFF_FLAGS, 0);
      wb(0, `OFF_FLAGS, 0);
      chk("flag kept", rdat, 32'h0000_0001 << bt[k]);
      wb(1, `OFF_ENABLE_CLEAR, 32'h0000_0001 << bt[k]);
      settle();
      chk("masked", irq, 0);
      wb(1, `OFF_ENABLE_SET, 32'h0000_0001 << bt[k]);
      settle();
      chk("unmasked", irq, 1);
      wb(1, `OFF_FLAGS, 32'h0000_0001 << bt[k]);
      settle();
      chk("cleared", irq, 0);
    end
    wb(0, `OFF_FRAME_NUMBER, 0);
    chk("frame number", rdat, 32'(frames) << 3);
    fgo <= 1'b0;
    ev(3, 16'h0050);
    wb(1, `OFF_FLAGS, {16'h0000, `IMPL_MASK});
    ev(6, 16'h0210);
    wb(1, `OFF_FLAGS, {16'h0000, `IMPL_MASK});
    {fgo, bpg} <= 2'b11;
    ev(5, 16'h0110);
    tally_and_finish();
  end
endmodule // usb_host_irq_enable_flag_tb
